// ---- nfhc_defs.svh ----
// nand host controller constants: command codes, address layout, timing counts
`ifndef NFHC_DEFS_SVH
`define NFHC_DEFS_SVH
// ****************************************
// command codes
// ****************************************
`define NFHC_CMD_READ_SETUP   8'h00
`define NFHC_CMD_READ_GO      8'h30
`define NFHC_CMD_COPY_READ    8'h3a
`define NFHC_CMD_COL_CHG      8'h05
`define NFHC_CMD_COL_GO       8'he0
`define NFHC_CMD_CACHE_RD     8'h31
`define NFHC_CMD_CACHE_LAST   8'h3f
`define NFHC_CMD_PROG_SETUP   8'h80
`define NFHC_CMD_PROG_GO      8'h10
`define NFHC_CMD_PROG_COL     8'h85
`define NFHC_CMD_MULTI_RD     8'h60
`define NFHC_CMD_RESET        8'hff
`define NFHC_CMD_STATUS       8'h70
// ****************************************
// address layout
// ****************************************
`define NFHC_COL_W            13
`define NFHC_PAGE_W           17
`define NFHC_INBLK_W          6
`define NFHC_PAGE_BYTES       4352
// ****************************************
// timing, ns and cycles at 10 mhz
// ****************************************
`define NFHC_CLK_NS           100
`define NFHC_STROBE_NS        100
`define NFHC_STROBE_CYC       ((`NFHC_STROBE_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS)
`define NFHC_BUSY_SETTLE_NS   200
`define NFHC_BUSY_SETTLE_CYC  ((`NFHC_BUSY_SETTLE_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS)
`endif

// ---- nfhc_pkg.sv ----
// nand host controller types
package nfhc_pkg;
	typedef enum logic [2:0] {
		NFHC_OP_READ,
		NFHC_OP_CACHE_RD,
		NFHC_OP_CACHE_LAST,
		NFHC_OP_COL_CHG,
		NFHC_OP_PROGRAM,
		NFHC_OP_MULTI_RD,
		NFHC_OP_RESET,
		NFHC_OP_STATUS
	} nfhc_op_e;
	typedef enum logic [1:0] {
		NFHC_BYTE_CMD,
		NFHC_BYTE_ADDR,
		NFHC_BYTE_WDATA,
		NFHC_BYTE_RDATA
	} nfhc_kind_e;
endpackage

// ---- nfhc_strobe.sv ----
// nand host controller: single-byte strobe engine on the shared io bus
`timescale 1ns/100ps
`include "nfhc_defs.svh"
module nfhc_strobe
	import nfhc_pkg::*;
#(
	parameter int unsigned STROBE_CYC = `NFHC_STROBE_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       go_i,
	input  nfhc_kind_e      kind_i,
	input  wire logic [7:0] byte_i,
	input  wire logic [7:0] io_sync_i,
	output logic            done_o,
	output logic [7:0]      rbyte_o,
	output logic            cle_o,
	output logic            ale_o,
	output logic            write_strobe_n_o,
	output logic            read_strobe_n_o,
	output logic [7:0]      io_o,
	output logic            io_oe_o
);
	initial begin
		if (STROBE_CYC < 1 || STROBE_CYC > 253) $error("strobe width out of range");
	end
	typedef enum logic [1:0] {NFHC_S_IDLE, NFHC_S_LOW, NFHC_S_HIGH} nfhc_sst_e;
	nfhc_sst_e  st_ff, nxt_st;
	logic [7:0] cnt_ff, nxt_cnt;
	logic       cle_ff, nxt_cle, ale_ff, nxt_ale, we_n_ff, nxt_we_n, re_n_ff, nxt_re_n;
	logic       oe_ff, nxt_oe, done_ff, nxt_done;
	logic [7:0] io_ff, nxt_io, rb_ff, nxt_rb;
	logic       is_rd_ff, nxt_is_rd;
	always_comb begin
		nxt_st    = st_ff;
		nxt_cnt   = cnt_ff;
		nxt_cle   = cle_ff;
		nxt_ale   = ale_ff;
		nxt_we_n  = we_n_ff;
		nxt_re_n  = re_n_ff;
		nxt_oe    = oe_ff;
		nxt_io    = io_ff;
		nxt_rb    = rb_ff;
		nxt_done  = 1'b0;
		nxt_is_rd = is_rd_ff;
		case (st_ff)
			NFHC_S_IDLE: begin
				if (go_i) begin
					// kind of byte shown by the latch enables
					nxt_cle   = (kind_i == NFHC_BYTE_CMD); // R1
					nxt_ale   = (kind_i == NFHC_BYTE_ADDR); // R1
					nxt_is_rd = (kind_i == NFHC_BYTE_RDATA);
					nxt_oe    = (kind_i != NFHC_BYTE_RDATA);
					nxt_io    = byte_i;
					nxt_we_n  = (kind_i == NFHC_BYTE_RDATA);
					nxt_re_n  = (kind_i != NFHC_BYTE_RDATA); // R23
					// reads stay low two extra cycles so the synchronised pin holds the new byte
					nxt_cnt   = (kind_i == NFHC_BYTE_RDATA) ? 8'(STROBE_CYC + 2) : 8'(STROBE_CYC); // R12
					nxt_st    = NFHC_S_LOW;
				end
			end
			NFHC_S_LOW: begin
				if (cnt_ff > 8'h01) begin
					nxt_cnt = cnt_ff - 8'h01;
				end else begin
					// rising write strobe latches the byte in the device
					if (is_rd_ff) nxt_rb = io_sync_i; // R12
					nxt_we_n = 1'b1; // R24
					nxt_re_n = 1'b1;
					nxt_cnt  = 8'(STROBE_CYC);
					nxt_st   = NFHC_S_HIGH;
				end
			end
			NFHC_S_HIGH: begin
				if (cnt_ff > 8'h01) begin
					nxt_cnt = cnt_ff - 8'h01;
				end else begin
					nxt_cle  = 1'b0;
					nxt_ale  = 1'b0;
					nxt_oe   = 1'b0;
					nxt_done = 1'b1;
					nxt_st   = NFHC_S_IDLE;
				end
			end
			default: nxt_st = NFHC_S_IDLE;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff    <= NFHC_S_IDLE;
			cnt_ff   <= 8'h00;
			cle_ff   <= 1'b0;
			ale_ff   <= 1'b0;
			we_n_ff  <= 1'b1;
			re_n_ff  <= 1'b1;
			oe_ff    <= 1'b0;
			io_ff    <= 8'h00;
			rb_ff    <= 8'h00;
			done_ff  <= 1'b0;
			is_rd_ff <= 1'b0;
		end else begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			cle_ff   <= nxt_cle;
			ale_ff   <= nxt_ale;
			we_n_ff  <= nxt_we_n;
			re_n_ff  <= nxt_re_n;
			oe_ff    <= nxt_oe;
			io_ff    <= nxt_io;
			rb_ff    <= nxt_rb;
			done_ff  <= nxt_done;
			is_rd_ff <= nxt_is_rd;
		end
	end
	assign done_o           = done_ff;
	assign rbyte_o          = rb_ff;
	assign cle_o            = cle_ff;
	assign ale_o            = ale_ff;
	assign write_strobe_n_o = we_n_ff;
	assign read_strobe_n_o  = re_n_ff;
	assign io_o             = io_ff;
	assign io_oe_o          = oe_ff;
	// ****************************************
	// assertions
	// ****************************************
	property p_latch_exclusive;
		@(posedge clk_i) disable iff (!rst_n_i) !(cle_ff && ale_ff);
	endproperty
	a_latch_exclusive: assert property (p_latch_exclusive) else $error("cle and ale both high"); // R1
	property p_read_no_drive;
		@(posedge clk_i) disable iff (!rst_n_i) !read_strobe_n_o |-> !io_oe_o;
	endproperty
	a_read_no_drive: assert property (p_read_no_drive) else $error("io driven during read strobe"); // R1
	property p_cmd_held;
		@(posedge clk_i) disable iff (!rst_n_i) $rose(write_strobe_n_o) && cle_ff |-> io_oe_o;
	endproperty
	a_cmd_held: assert property (p_cmd_held) else $error("command byte not driven at latch edge"); // R24
endmodule

// ---- nfhc_host.sv ----
// nand host controller: command, address and data sequencer driving the nand pins
`timescale 1ns/100ps
`include "nfhc_defs.svh"
// Functional notes
// R1: commands, addresses and data share eight io lines; latch enables tell them apart
// R2: a page holds 4096 main bytes plus 256 spare bytes
// R3: a block holds 64 pages; erase works on whole blocks
// R4: five address bytes: column low, column high, page low, page mid, page bit 16
// R5: page bits 5..0 select page in block, bits 16..6 select block
// R6: read codes 00/30, 05/e0, 31, 3f, 00/3a
// R7: program codes 80/10, 85, 80/15, 80/11, 81/15, 81/10, 8c/15, 8c/10
// R8: erase 60/d0, id 90, status 70/71, reset ff; busy accepts only 70, 71, ff
// R9: after power-up while busy, only reset or status commands may be sent
// R10: power-up preloads read setup, so first read needs address and 30 only
// R11: 30 rising strobe starts array read; device busy, then ready
// R12: read data comes one byte per read strobe from the addressed column
// R13: 05, two column bytes, e0 move output column, repeatable
// R14: 31 copies buffer to cache then fetches the next page
// R15: 3f moves last fetched page without new fetch
// R16: cached reads restart from a normal read when block changes
// R17: two districts: even blocks district 0, odd blocks district 1
// R18: multi read: two 60-prefixed address sets, one block per district, same page bits, then 30
// R19: the two district sets may come in either order
// R20: 80, address, data, then 10 starts automatic program
// R21: device verifies programmed page internally
// R22: device holds a data cache and page buffer of one page each
// R23: each read strobe falling edge advances the column counter
// R24: command byte latched on write strobe rising edge with cle high
// R25: ready/busy is open drain, low while an operation runs
// R26: write protect low blocks program and erase
// R27: reset command aborts any operation and returns ready
module nfhc_host
	import nfhc_pkg::*;
#(
	parameter int unsigned MAX_XFER = `NFHC_PAGE_BYTES
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   req_valid_i,
	input  nfhc_op_e                    req_op_i,
	input  wire logic [`NFHC_COL_W-1:0] req_col_i,
	input  wire logic [`NFHC_PAGE_W-1:0] req_page_i,
	input  wire logic [`NFHC_PAGE_W-1:0] req_page2_i,
	input  wire logic [12:0]            req_len_i,
	input  wire logic                   wdata_valid_i,
	input  wire logic [7:0]             wdata_i,
	input  wire logic [7:0]             io_i,
	input  wire logic                   ready_busy_n_i,
	output logic                        req_ready_o,
	output logic                        req_error_o,
	output logic                        wdata_ready_o,
	output logic                        rdata_valid_o,
	output logic [7:0]                  rdata_o,
	output logic                        done_o,
	output logic                        cle_o,
	output logic                        ale_o,
	output logic                        chip_en_n_o,
	output logic                        write_strobe_n_o,
	output logic                        read_strobe_n_o,
	output logic                        write_protect_n_o,
	output logic [7:0]                  io_o,
	output logic                        io_oe_o
);
	initial begin
		if (MAX_XFER < 1 || MAX_XFER > `NFHC_PAGE_BYTES) $error("transfer length out of range"); // R2 R22
	end
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [7:0] io_m_ff, io_s_ff;
	logic       rb_m_ff, rb_s_ff;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			io_m_ff <= 8'h00;
			io_s_ff <= 8'h00;
			rb_m_ff <= 1'b0;
			rb_s_ff <= 1'b0;
		end else begin
			io_m_ff <= io_i;
			io_s_ff <= io_m_ff;
			rb_m_ff <= ready_busy_n_i;
			rb_s_ff <= rb_m_ff;
		end
	end
	// ****************************************
	// byte list builder
	// ****************************************
	function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [`NFHC_COL_W-1:0] col,
		input logic [`NFHC_PAGE_W-1:0] pg);
		case (idx)
			3'h0:    addr_byte = col[7:0];
			3'h1:    addr_byte = {3'h0, col[12:8]}; // R4
			3'h2:    addr_byte = pg[7:0];
			3'h3:    addr_byte = pg[15:8];
			default: addr_byte = {7'h00, pg[16]}; // R4
		endcase
	endfunction
	typedef enum logic [3:0] {
		NFHC_IDLE, NFHC_CMD1, NFHC_ADDR, NFHC_CMD_MID, NFHC_ADDR2, NFHC_WDATA,
		NFHC_CMD2, NFHC_SETTLE, NFHC_WAIT, NFHC_RDATA, NFHC_FINISH
	} nfhc_st_e;
	nfhc_st_e                 st_ff, nxt_st;
	nfhc_op_e                 op_ff, nxt_op;
	logic [`NFHC_COL_W-1:0]   col_ff, nxt_col;
	logic [`NFHC_PAGE_W-1:0]  pg_ff, nxt_pg, pg2_ff, nxt_pg2, blk_ff, nxt_blk;
	logic [12:0]              len_ff, nxt_len;
	logic [2:0]               idx_ff, nxt_idx, nadr_ff, nxt_nadr;
	logic [7:0]               set_cnt_ff, nxt_set_cnt;
	logic                     busy_ff, nxt_busy, cached_ff, nxt_cached;
	logic                     go_ff, nxt_go, err_ff, nxt_err, done_ff, nxt_done;
	logic                     rv_ff, nxt_rv, wr_ff, nxt_wr, wp_n_ff, nxt_wp_n;
	nfhc_kind_e               kind_ff, nxt_kind;
	logic [7:0]               byte_ff, nxt_byte, rbyte;
	logic                     sdone;
	logic                     same_blk;
	nfhc_strobe u_strobe (
		.clk_i            (clk_i),
		.rst_n_i          (rst_n_i),
		.go_i             (go_ff),
		.kind_i           (kind_ff),
		.byte_i           (byte_ff),
		.io_sync_i        (io_s_ff),
		.done_o           (sdone),
		.rbyte_o          (rbyte),
		.cle_o            (cle_o),
		.ale_o            (ale_o),
		.write_strobe_n_o (write_strobe_n_o),
		.read_strobe_n_o  (read_strobe_n_o),
		.io_o             (io_o),
		.io_oe_o          (io_oe_o)
	);
	assign same_blk = (req_page_i[16:6] == blk_ff[16:6]); // R3 R5
	always_comb begin
		nxt_st      = st_ff;
		nxt_op      = op_ff;
		nxt_col     = col_ff;
		nxt_pg      = pg_ff;
		nxt_pg2     = pg2_ff;
		nxt_blk     = blk_ff;
		nxt_len     = len_ff;
		nxt_idx     = idx_ff;
		nxt_nadr    = nadr_ff;
		nxt_set_cnt = set_cnt_ff;
		nxt_busy    = busy_ff;
		nxt_cached  = cached_ff;
		nxt_go      = 1'b0;
		nxt_err     = 1'b0;
		nxt_done    = 1'b0;
		nxt_rv      = 1'b0;
		nxt_wr      = 1'b0;
		nxt_wp_n    = wp_n_ff;
		nxt_kind    = kind_ff;
		nxt_byte    = byte_ff;
		case (st_ff)
			NFHC_IDLE: begin
				nxt_busy = !rb_s_ff; // R25
				if (req_valid_i) begin
					nxt_op  = req_op_i;
					nxt_col = req_col_i;
					nxt_pg  = req_page_i;
					nxt_pg2 = req_page2_i;
					nxt_len = req_len_i;
					nxt_idx = 3'h0;
					nxt_set_cnt = 8'h00;
					nxt_kind = NFHC_BYTE_CMD;
					nxt_go   = 1'b1;
					nxt_st   = NFHC_CMD1;
					if (busy_ff && req_op_i != NFHC_OP_RESET && req_op_i != NFHC_OP_STATUS) begin
						nxt_err = 1'b1; // R8 R9
						nxt_go  = 1'b0;
						nxt_st  = NFHC_IDLE;
					end else if ((req_op_i == NFHC_OP_CACHE_RD || req_op_i == NFHC_OP_CACHE_LAST) &&
						!(cached_ff && same_blk)) begin
						nxt_err = 1'b1; // R16
						nxt_go  = 1'b0;
						nxt_st  = NFHC_IDLE;
					end else if (req_op_i == NFHC_OP_MULTI_RD &&
						(req_page_i[6] == req_page2_i[6] || req_page_i[5:0] != req_page2_i[5:0])) begin
						nxt_err = 1'b1; // R17 R18
						nxt_go  = 1'b0;
						nxt_st  = NFHC_IDLE;
					end
					case (req_op_i)
						NFHC_OP_READ:       begin nxt_byte = `NFHC_CMD_READ_SETUP; nxt_nadr = 3'h5; end // R6 R10
						NFHC_OP_CACHE_RD:   begin nxt_byte = `NFHC_CMD_CACHE_RD;   nxt_nadr = 3'h0; end // R14
						NFHC_OP_CACHE_LAST: begin nxt_byte = `NFHC_CMD_CACHE_LAST; nxt_nadr = 3'h0; end // R15
						NFHC_OP_COL_CHG:    begin nxt_byte = `NFHC_CMD_COL_CHG;    nxt_nadr = 3'h2; end // R13
						NFHC_OP_PROGRAM:    begin nxt_byte = `NFHC_CMD_PROG_SETUP; nxt_nadr = 3'h5; end // R7 R20
						NFHC_OP_MULTI_RD:   begin nxt_byte = `NFHC_CMD_MULTI_RD;   nxt_nadr = 3'h3; end // R18
						NFHC_OP_RESET:      begin nxt_byte = `NFHC_CMD_RESET;      nxt_nadr = 3'h0; end // R27
						default:            begin nxt_byte = `NFHC_CMD_STATUS;     nxt_nadr = 3'h0; end
					endcase
					nxt_wp_n = (req_op_i == NFHC_OP_PROGRAM) && nxt_go; // R26
				end
			end
			NFHC_CMD1, NFHC_CMD_MID: begin
				if (sdone) begin
					if (nadr_ff != 3'h0) begin
						nxt_kind = NFHC_BYTE_ADDR;
						nxt_idx  = (op_ff == NFHC_OP_MULTI_RD) ? 3'h2 : 3'h0;
						nxt_byte = addr_byte((op_ff == NFHC_OP_MULTI_RD) ? 3'h2 : 3'h0, col_ff,
							(set_cnt_ff == 8'h01) ? pg2_ff : pg_ff);
						nxt_go   = 1'b1;
						nxt_st   = NFHC_ADDR;
					end else if (op_ff == NFHC_OP_STATUS) begin
						nxt_kind = NFHC_BYTE_RDATA;
						nxt_len  = 13'h0001;
						nxt_go   = 1'b1;
						nxt_st   = NFHC_RDATA;
					end else begin
						nxt_st      = NFHC_SETTLE;
						nxt_len     = (op_ff == NFHC_OP_RESET) ? 13'h0000 : len_ff;
						// only the settle path reloads the counter; it marks the second set otherwise
						nxt_set_cnt = 8'(`NFHC_BUSY_SETTLE_CYC);
					end
				end
			end
			NFHC_ADDR: begin
				if (sdone) begin
					if (idx_ff == 3'h4 || (op_ff == NFHC_OP_COL_CHG && idx_ff == 3'h1)) begin
						nxt_kind = (op_ff == NFHC_OP_PROGRAM) ? NFHC_BYTE_WDATA : NFHC_BYTE_CMD;
						if (op_ff == NFHC_OP_MULTI_RD && pg2_ff != pg_ff && nadr_ff == 3'h3) begin
							nxt_byte = `NFHC_CMD_MULTI_RD; // R19
							nxt_nadr = 3'h4;
							nxt_set_cnt = 8'h01;
							nxt_go   = 1'b1;
							nxt_st   = NFHC_CMD_MID;
						end else if (op_ff == NFHC_OP_PROGRAM) begin
							nxt_wr = 1'b1;
							nxt_st = NFHC_WDATA;
						end else begin
							nxt_byte = (op_ff == NFHC_OP_COL_CHG) ? `NFHC_CMD_COL_GO : `NFHC_CMD_READ_GO; // R11
							nxt_go   = 1'b1;
							nxt_st   = NFHC_CMD2;
						end
					end else begin
						nxt_idx  = idx_ff + 3'h1;
						nxt_byte = addr_byte(idx_ff + 3'h1, col_ff, (set_cnt_ff == 8'h01) ? pg2_ff : pg_ff);
						nxt_go   = 1'b1;
					end
				end
			end
			NFHC_WDATA: begin
				if (len_ff == 13'h0000) begin
					// confirm byte waits until the last data strobe has finished
					if (sdone || wr_ff) begin
						nxt_kind = NFHC_BYTE_CMD;
						nxt_byte = `NFHC_CMD_PROG_GO; // R20
						nxt_go   = 1'b1;
						nxt_st   = NFHC_CMD2;
					end
				end else if (sdone || wr_ff) begin
					nxt_wr = 1'b1;
					if (wdata_valid_i && wr_ff) begin
						nxt_byte = wdata_i;
						nxt_len  = len_ff - 13'h0001;
						nxt_go   = 1'b1;
						nxt_wr   = 1'b0;
					end
				end
			end
			NFHC_CMD2: begin
				if (sdone) begin
					nxt_set_cnt = 8'(`NFHC_BUSY_SETTLE_CYC);
					nxt_st      = NFHC_SETTLE;
					if (op_ff == NFHC_OP_PROGRAM) nxt_len = 13'h0000;
				end
			end
			NFHC_SETTLE: begin
				// device needs time to pull ready/busy low after the confirm edge
				if (set_cnt_ff > 8'h01) nxt_set_cnt = set_cnt_ff - 8'h01;
				else nxt_st = NFHC_WAIT;
			end
			NFHC_WAIT: begin
				if (rb_s_ff) begin // R21 R25
					if (op_ff == NFHC_OP_READ || op_ff == NFHC_OP_MULTI_RD) begin
						nxt_cached = 1'b1;
						nxt_blk    = pg_ff;
					end
					if (op_ff == NFHC_OP_CACHE_LAST || op_ff == NFHC_OP_RESET || op_ff == NFHC_OP_PROGRAM)
						nxt_cached = 1'b0; // R15 R27
					if (len_ff != 13'h0000) begin
						nxt_kind = NFHC_BYTE_RDATA;
						nxt_go   = 1'b1;
						nxt_st   = NFHC_RDATA;
					end else begin
						nxt_st = NFHC_FINISH;
					end
				end
			end
			NFHC_RDATA: begin
				if (sdone) begin
					nxt_rv  = 1'b1; // R12
					nxt_len = len_ff - 13'h0001;
					if (len_ff == 13'h0001) nxt_st = NFHC_FINISH;
					else nxt_go = 1'b1; // R23
				end
			end
			NFHC_FINISH: begin
				nxt_done = 1'b1;
				nxt_wp_n = 1'b0;
				nxt_st   = NFHC_IDLE;
			end
			default: nxt_st = NFHC_IDLE;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff      <= NFHC_IDLE;
			op_ff      <= NFHC_OP_READ;
			col_ff     <= '0;
			pg_ff      <= '0;
			pg2_ff     <= '0;
			blk_ff     <= '0;
			len_ff     <= 13'h0000;
			idx_ff     <= 3'h0;
			nadr_ff    <= 3'h0;
			set_cnt_ff <= 8'h00;
			busy_ff    <= 1'b1;
			cached_ff  <= 1'b0;
			go_ff      <= 1'b0;
			err_ff     <= 1'b0;
			done_ff    <= 1'b0;
			rv_ff      <= 1'b0;
			wr_ff      <= 1'b0;
			wp_n_ff    <= 1'b0;
			kind_ff    <= NFHC_BYTE_CMD;
			byte_ff    <= 8'h00;
		end else begin
			st_ff      <= nxt_st;
			op_ff      <= nxt_op;
			col_ff     <= nxt_col;
			pg_ff      <= nxt_pg;
			pg2_ff     <= nxt_pg2;
			blk_ff     <= nxt_blk;
			len_ff     <= nxt_len;
			idx_ff     <= nxt_idx;
			nadr_ff    <= nxt_nadr;
			set_cnt_ff <= nxt_set_cnt;
			busy_ff    <= nxt_busy;
			cached_ff  <= nxt_cached;
			go_ff      <= nxt_go;
			err_ff     <= nxt_err;
			done_ff    <= nxt_done;
			rv_ff      <= nxt_rv;
			wr_ff      <= nxt_wr;
			wp_n_ff    <= nxt_wp_n;
			kind_ff    <= nxt_kind;
			byte_ff    <= nxt_byte;
		end
	end
	logic ready_ff;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) ready_ff <= 1'b0;
		else ready_ff <= (nxt_st == NFHC_IDLE) && !req_valid_i;
	end
	assign req_ready_o       = ready_ff;
	assign req_error_o       = err_ff;
	assign wdata_ready_o     = wr_ff;
	assign rdata_valid_o     = rv_ff;
	assign rdata_o           = rbyte;
	assign done_o            = done_ff;
	assign chip_en_n_o       = 1'b0;
	assign write_protect_n_o = wp_n_ff;
	// ****************************************
	// assertions
	// ****************************************
	property p_busy_refuse;
		@(posedge clk_i) disable iff (!rst_n_i)
		st_ff == NFHC_IDLE && busy_ff && req_valid_i && req_op_i == NFHC_OP_PROGRAM |=> err_ff && st_ff == NFHC_IDLE;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("program sent while busy"); // R8
	property p_wp_idle;
		@(posedge clk_i) disable iff (!rst_n_i) op_ff != NFHC_OP_PROGRAM && st_ff != NFHC_IDLE |-> !wp_n_ff;
	endproperty
	a_wp_idle: assert property (p_wp_idle) else $error("write protect released outside program"); // R26
	property p_wait_ready;
		@(posedge clk_i) disable iff (!rst_n_i) st_ff == NFHC_WAIT && !rb_s_ff |=> st_ff == NFHC_WAIT;
	endproperty
	a_wait_ready: assert property (p_wait_ready) else $error("left wait while device busy"); // R25
	property p_rd_count;
		@(posedge clk_i) disable iff (!rst_n_i) rv_ff && st_ff == NFHC_RDATA |-> len_ff != 13'h0000;
	endproperty
	a_rd_count: assert property (p_rd_count) else $error("read byte count underflow"); // R12
	property p_cache_guard;
		@(posedge clk_i) disable iff (!rst_n_i)
		st_ff == NFHC_IDLE && req_valid_i && req_op_i == NFHC_OP_CACHE_RD && !cached_ff |=> err_ff;
	endproperty
	a_cache_guard: assert property (p_cache_guard) else $error("cached read without base read"); // R16
	property p_multi_district;
		@(posedge clk_i) disable iff (!rst_n_i) st_ff == NFHC_CMD_MID |-> pg_ff[6] != pg2_ff[6];
	endproperty
	a_multi_district: assert property (p_multi_district) else $error("multi read same district"); // R17
	property p_col_high;
		@(posedge clk_i) disable iff (!rst_n_i) st_ff == NFHC_ADDR && idx_ff == 3'h1 |-> byte_ff[7:5] == 3'h0;
	endproperty
	a_col_high: assert property (p_col_high) else $error("column high byte top bits set"); // R4
	property p_settle;
		@(posedge clk_i) disable iff (!rst_n_i) st_ff == NFHC_CMD2 && sdone |=> st_ff == NFHC_SETTLE;
	endproperty
	a_settle: assert property (p_settle) else $error("no settle after confirm"); // R11
endmodule

// ---- nfhc_dev_model.sv ----
// nand device model: latches commands, addresses and data, answers with busy and read bytes
`timescale 1ns/100ps
module nfhc_dev_model (
	input  wire logic       cle_i,
	input  wire logic       ale_i,
	input  wire logic       write_strobe_n_i,
	input  wire logic       read_strobe_n_i,
	input  wire logic       write_protect_n_i,
	input  wire logic [7:0] io_i,
	output logic [7:0]      io_o,
	output logic            ready_busy_n_o
);
	logic [7:0]  cmd_ff;
	logic [12:0] col_ff;
	logic [16:0] page_ff;
	logic [7:0]  wlast_ff;
	logic        busy_ff;
	logic        wp_ok_ff;
	int          acnt;
	int          wcnt;
	initial begin
		cmd_ff = 8'h00;
		busy_ff = 1'b1;
		io_o = 8'h5a;
		busy_ff <= #3000 1'b0;
	end
	assign ready_busy_n_o = ~busy_ff;
	always @(posedge write_strobe_n_i) begin
		if (cle_i) begin
			cmd_ff = io_i;
			// a 60 set carries page bytes only
			acnt = (io_i == 8'h60) ? 2 : 0;
			if (io_i == 8'h80)
				wcnt = 0;
			if (io_i == 8'h10)
				wp_ok_ff = write_protect_n_i;
			if (io_i inside {8'h30, 8'h10, 8'hff}) begin
				busy_ff = 1'b1;
				busy_ff <= #2000 1'b0;
			end
		end else if (ale_i) begin
			case (acnt)
				0: col_ff[7:0] = io_i;
				1: col_ff[12:8] = io_i[4:0];
				2: page_ff[7:0] = io_i;
				3: page_ff[15:8] = io_i;
				default: page_ff[16] = io_i[0];
			endcase
			acnt++;
		end else begin
			wcnt++;
			wlast_ff = io_i;
		end
	end
	// status byte carries ready on bit 6, otherwise page data pattern
	always @(negedge read_strobe_n_i) begin
		io_o = (cmd_ff == 8'h70) ? {1'b0, ~busy_ff, 6'h00} : col_ff[7:0] ^ page_ff[7:0];
		col_ff++;
	end
endmodule

// ---- nfhc_host_tb.sv ----
// testbench for the nand host controller against the device model
`timescale 1ns/100ps
module nfhc_host_tb
	import nfhc_pkg::*;
();
	logic        clk_i, rst_n_i, req_valid_i, wdata_valid_i, ready_busy_n_i;
	nfhc_op_e    req_op_i;
	logic [12:0] req_col_i, req_len_i, col;
	logic [16:0] req_page_i, req_page2_i, page;
	logic [7:0]  wdata_i, io_i, rdata_o, io_o;
	logic        req_ready_o, req_error_o, wdata_ready_o, rdata_valid_o, done_o, cle_o, ale_o;
	logic        chip_en_n_o, write_strobe_n_o, read_strobe_n_o, write_protect_n_o, io_oe_o;
	logic [7:0]  exp_q[$];
	logic [16:0] seed = 17'd78679;
	int          num_errors, total_checks, cyc;
	nfhc_host i_dut (.*);
	nfhc_dev_model i_dev (.cle_i(cle_o), .ale_i(ale_o), .write_strobe_n_i(write_strobe_n_o),
		.read_strobe_n_i(read_strobe_n_o), .write_protect_n_i(write_protect_n_o), .io_i(io_o),
		.io_o(io_i), .ready_busy_n_o(ready_busy_n_i));
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task check(input string nm, input logic [16:0] seen, input logic [16:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task run(input nfhc_op_e op, input logic [12:0] c, input logic [16:0] p, p2, input logic [12:0] n, input logic e);
		@(negedge clk_i);
		while (req_ready_o !== 1'b1)
			@(negedge clk_i);
		req_op_i    = op;
		req_col_i   = c;
		req_page_i  = p;
		req_page2_i = p2;
		req_len_i   = n;
		req_valid_i = 1'b1;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		while (!(done_o === 1'b1 || req_error_o === 1'b1))
			@(negedge clk_i);
		check("refused", {12'h000, req_error_o}, {12'h000, e});
		$display("test op %0d done", op);
	endtask
	// expected bytes follow the column counter from the requested start
	task rd(input nfhc_op_e op, input logic [12:0] c, input logic [16:0] p, input logic [12:0] n);
		for (int i = 0; i < n; i++)
			exp_q.push_back(8'(c + i) ^ p[7:0]);
		run(op, c, p, p, n, 1'b0);
	endtask
	always @(negedge clk_i) begin
		if (rdata_valid_o === 1'b1) begin
			if (exp_q.size() == 0)
				check("extra byte", 13'h0001, 13'h0000);
			else
				check("rdata", {5'h00, rdata_o}, {5'h00, exp_q.pop_front()});
		end
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			finish_test();
		end
	end
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		{rst_n_i, req_valid_i, wdata_valid_i, req_col_i, req_len_i, wdata_i} = '0;
		req_op_i = NFHC_OP_READ;
		req_page_i = 17'h00000;
		req_page2_i = 17'h00000;
		repeat (4) @(negedge clk_i);
		rst_n_i = 1'b1;
		run(NFHC_OP_READ, 13'h0, 17'h0, 17'h0, 13'h1, 1'b1);
		exp_q.push_back(8'h00);
		run(NFHC_OP_STATUS, 13'h0, 17'h0, 17'h0, 13'h1, 1'b0);
		while (ready_busy_n_i !== 1'b1)
			@(negedge clk_i);
		repeat (4) @(negedge clk_i);
		exp_q.push_back(8'h40);
		run(NFHC_OP_STATUS, 13'h0, 17'h0, 17'h0, 13'h1, 1'b0);
		for (int t = 0; t < 3; t++) begin
			seed = lfsr(seed);
			col = {1'b0, seed[11:0]};
			page = seed;
			rd(NFHC_OP_READ, col, page, 13'h4);
			rd(NFHC_OP_COL_CHG, col ^ 13'h0a5, page, 13'h3);
			rd(NFHC_OP_COL_CHG, col ^ 13'h1f0, page, 13'h2);
		end
		run(NFHC_OP_MULTI_RD, col, page, page ^ 17'h00080, 13'h1, 1'b1);
		run(NFHC_OP_MULTI_RD, col, page, page ^ 17'h00041, 13'h1, 1'b1);
		run(NFHC_OP_MULTI_RD, col, page, page ^ 17'h1ff40, 13'h0, 1'b0);
		check("multi page", i_dev.page_ff, page ^ 17'h1ff40);
		run(NFHC_OP_CACHE_LAST, col, page, page, 13'h0, 1'b0);
		check("last cache cmd", {9'h000, i_dev.cmd_ff}, 17'h0003f);
		run(NFHC_OP_CACHE_RD, col, page ^ 17'h00040, page ^ 17'h00040, 13'h2, 1'b1);
		seed = lfsr(seed);
		wdata_i = seed[7:0];
		wdata_valid_i = 1'b1;
		run(NFHC_OP_PROGRAM, col, page, page, 13'h5, 1'b0);
		wdata_valid_i = 1'b0;
		check("written count", 13'(i_dev.wcnt), 13'h5);
		check("last written", {5'h00, i_dev.wlast_ff}, {5'h00, wdata_i});
		check("write protect", {12'h000, i_dev.wp_ok_ff}, 13'h1);
		run(NFHC_OP_RESET, 13'h0, 17'h0, 17'h0, 13'h0, 1'b0);
		check("reset cmd", {5'h00, i_dev.cmd_ff}, 13'h0ff);
		check("bytes left", 17'(exp_q.size()), 17'h00000);
		finish_test();
	end
endmodule
